// file: aaq_exec.sv
// execution unit for add_to_address_register, add_immediate, add_quick
// assumes operands fetched by shared address-mode logic; one op per start
`timescale 1ns/100ps
module aaq_exec (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [15:0] opcode_i,
    input wire logic [15:0] ext0_i,
    input wire logic [15:0] ext1_i,
    input wire logic [31:0] src_i,
    input wire logic [31:0] dst_i,
    input wire logic [4:0] ccr_i,
    output logic done_o,
    output logic illegal_o,
    output logic [31:0] result_o,
    output logic [4:0] ccr_o,
    output logic areg_wr_o,
    output logic [2:0] areg_sel_o,
    output logic [1:0] size_o,
    output logic [1:0] ext_words_o
);
    typedef struct packed {
        logic done;
        logic illegal;
        logic [31:0] result;
        logic [4:0] ccr;
        logic areg_wr;
        logic [2:0] areg_sel;
        logic [1:0] size;
        logic [1:0] ext_words;
    } aaq_state_t;

    aaq_state_t st_ff;
    aaq_state_t nxt_st;
    aaq_pkg::aaq_op_t op;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic [1:0] sz;
    logic [31:0] opnd;
    logic [31:0] addend;
    logic [1:0] add_size;
    logic [31:0] sum;
    logic [4:0] flags;
    logic legal;
    logic to_areg;
    logic alterable;
    logic data_alt;

    assign ea_mode = opcode_i[5:3];
    assign ea_reg = opcode_i[2:0];
    assign sz = opcode_i[7:6];

    // opcode recognition
    always_comb begin
        op = aaq_pkg::AAQ_OP_NONE;
        if (opcode_i[15:12] == aaq_pkg::QUICK_TOP && !opcode_i[8]) begin
            op = aaq_pkg::AAQ_OP_QUICK;
        end else if (opcode_i[15:12] == aaq_pkg::ADDR_TOP &&
                (opcode_i[8:6] == aaq_pkg::OPK_WORD ||
                 opcode_i[8:6] == aaq_pkg::OPK_LONG)) begin
            op = aaq_pkg::AAQ_OP_ADDR;
        end else if (opcode_i[15:8] == aaq_pkg::IMM_TOP) begin
            op = aaq_pkg::AAQ_OP_IMM;
        end
    end

    // destination mode classes; pc-relative and immediate are not alterable
    always_comb begin
        alterable = (ea_mode != aaq_pkg::MODE_MISC) ||
            ea_reg == aaq_pkg::MISC_ABS_W || ea_reg == aaq_pkg::MISC_ABS_L;
        data_alt = alterable && ea_mode != aaq_pkg::MODE_AREG;
    end

    // operand selection and legality
    always_comb begin
        to_areg = 1'b0;
        addend = src_i;
        add_size = sz;
        opnd = dst_i;
        legal = 1'b0;
        case (op)
            aaq_pkg::AAQ_OP_ADDR: begin
                // sign-extend word source to 32 bits
                if (opcode_i[8]) begin
                    addend = src_i;
                end else begin
                    addend = {{16{src_i[15]}}, src_i[15:0]};
                end
                // always a full 32-bit register sum
                add_size = aaq_pkg::SZ_LONG;
                to_areg = 1'b1;
                legal = 1'b1;
            end
            aaq_pkg::AAQ_OP_IMM: begin
                case (sz)
                    aaq_pkg::SZ_BYTE: addend = {24'h0, ext0_i[7:0]};
                    aaq_pkg::SZ_WORD: addend = {16'h0, ext0_i};
                    default: addend = {ext0_i, ext1_i};
                endcase
                // size 11 is not a size
                legal = data_alt && sz != 2'h3;
            end
            aaq_pkg::AAQ_OP_QUICK: begin
                if (opcode_i[11:9] == 3'h0) begin
                    addend = {28'h0, aaq_pkg::QUICK_EIGHT};
                end else begin
                    addend = {29'h0, opcode_i[11:9]};
                end
                // address register: whole register, no byte size
                if (ea_mode == aaq_pkg::MODE_AREG) begin
                    to_areg = 1'b1;
                    add_size = aaq_pkg::SZ_LONG;
                end
                legal = alterable && sz != 2'h3 &&
                    !(ea_mode == aaq_pkg::MODE_AREG && sz == aaq_pkg::SZ_BYTE);
            end
            default: legal = 1'b0;
        endcase
    end

    aaq_adder aaq_adder_i (
        .a_i(opnd),
        .b_i(addend),
        .size_i(add_size),
        .sum_o(sum),
        .flags_o(flags)
    );

    // next state; illegal forms keep result as it was and load flags from ccr_i
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.illegal = 1'b0;
        nxt_st.areg_wr = 1'b0;
        if (start_i) begin
            nxt_st.size = sz;
            nxt_st.areg_sel = opcode_i[11:9];
            nxt_st.ext_words = 2'h0;
            if (op == aaq_pkg::AAQ_OP_IMM) begin
                nxt_st.ext_words = (sz == aaq_pkg::SZ_LONG) ? 2'h2 : 2'h1;
            end
            if (op == aaq_pkg::AAQ_OP_ADDR) begin
                nxt_st.size = opcode_i[8] ? aaq_pkg::SZ_LONG
                    : aaq_pkg::SZ_WORD;
            end
            if (!legal) begin
                nxt_st.illegal = 1'b1;
                nxt_st.ccr = ccr_i;
            end else begin
                nxt_st.done = 1'b1;
                nxt_st.result = sum;
                if (op == aaq_pkg::AAQ_OP_QUICK && to_areg) begin
                    nxt_st.areg_sel = ea_reg;
                end
                nxt_st.areg_wr = to_areg;
                nxt_st.ccr = to_areg ? ccr_i : flags;
            end
        end
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{done: 1'b0, illegal: 1'b0,
                result: aaq_pkg::RESULT_RESET, ccr: aaq_pkg::CCR_RESET,
                areg_wr: 1'b0, areg_sel: 3'h0, size: 2'h0, ext_words: 2'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;
    assign illegal_o = st_ff.illegal;
    assign result_o = st_ff.result;
    assign ccr_o = st_ff.ccr;
    assign areg_wr_o = st_ff.areg_wr;
    assign areg_sel_o = st_ff.areg_sel;
    assign size_o = st_ff.size;
    assign ext_words_o = st_ff.ext_words;

    // address add leaves flags as given
    a_addr_flags_kept: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_ADDR |=> ccr_o == $past(ccr_i))
        else $error("address add changed flags");

    // word address add sign-extends
    a_addr_sext: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_ADDR && !opcode_i[8] |=>
        result_o == $past(dst_i) + {{16{$past(src_i[15])}},
        $past(src_i[15:0])})
        else $error("word address add wrong sum");

    // destination register number
    a_addr_dest: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_ADDR |=>
        areg_wr_o && areg_sel_o == $past(opcode_i[11:9]))
        else $error("address add wrong destination");

    // every source mode accepted
    a_addr_any_mode: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_ADDR |=> done_o && !illegal_o)
        else $error("address add refused");

    // byte immediate uses low byte only
    a_imm_byte: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_IMM && legal &&
        sz == aaq_pkg::SZ_BYTE |=>
        result_o[7:0] == 8'($past(dst_i[7:0]) + $past(ext0_i[7:0])))
        else $error("byte immediate wrong");

    // extend follows carry on flag-setting ops
    a_x_is_c: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_o && !$past(to_areg) |-> ccr_o[4] == ccr_o[0])
        else $error("extend differs from carry");

    // immediate into address register refused
    a_imm_no_areg: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_IMM && ea_mode == aaq_pkg::MODE_AREG
        |=> illegal_o && !done_o)
        else $error("immediate to address register taken");

    // quick zero field adds eight
    a_quick_eight: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_QUICK && legal &&
        opcode_i[11:9] == 3'h0 && ea_mode == aaq_pkg::MODE_AREG |=>
        result_o == $past(dst_i) + 32'h8)
        else $error("quick zero not eight");

    // quick to address register keeps flags
    a_quick_areg: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_QUICK && legal &&
        ea_mode == aaq_pkg::MODE_AREG |=>
        areg_wr_o && ccr_o == $past(ccr_i))
        else $error("quick address add changed flags");

    // zero flag judged on the sized result, not the whole word
    a_quick_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_QUICK && legal && !to_areg |=>
        ccr_o[2] == (size_o == aaq_pkg::SZ_BYTE ? result_o[7:0] == 8'h0 :
        size_o == aaq_pkg::SZ_WORD ? result_o[15:0] == 16'h0 :
        result_o == 32'h0))
        else $error("quick zero flag wrong");

    // quick rejects pc-relative and immediate
    a_quick_mode: assert property (
        @(posedge clk_i) disable iff (rst_i)
        start_i && op == aaq_pkg::AAQ_OP_QUICK &&
        ea_mode == aaq_pkg::MODE_MISC && ea_reg >= aaq_pkg::MISC_PC_D16
        |=> illegal_o)
        else $error("quick bad mode taken");
endmodule

// file: aaq_pkg.sv
// constants for the add-address/immediate/quick execution block
// assumes a 32-bit core with 16-bit opcode and extension words
package aaq_pkg;
    localparam logic [3:0] QUICK_TOP = 4'h5; // add_quick bits 15:12
    localparam logic [3:0] ADDR_TOP = 4'hd; // address add bits 15:12
    localparam logic [7:0] IMM_TOP = 8'h06; // add_immediate bits 15:8
    localparam logic [2:0] OPK_WORD = 3'h3; // operation kind, word
    localparam logic [2:0] OPK_LONG = 3'h7; // operation kind, long
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [2:0] MODE_DREG = 3'h0;
    localparam logic [2:0] MODE_AREG = 3'h1;
    localparam logic [2:0] MODE_MISC = 3'h7;
    localparam logic [2:0] MISC_ABS_W = 3'h0;
    localparam logic [2:0] MISC_ABS_L = 3'h1;
    localparam logic [2:0] MISC_PC_D16 = 3'h2;
    localparam logic [2:0] MISC_PC_IDX = 3'h3;
    localparam logic [2:0] MISC_IMM = 3'h4;
    localparam logic [3:0] QUICK_EIGHT = 4'h8; // quick field 0 means eight
    localparam logic [4:0] CCR_RESET = 5'h00; // x n z v c
    localparam logic [31:0] RESULT_RESET = 32'h0;
    typedef enum logic [1:0] {
        AAQ_OP_NONE,
        AAQ_OP_ADDR,
        AAQ_OP_IMM,
        AAQ_OP_QUICK
    } aaq_op_t;
endpackage

// file: aaq_adder.sv
// sized adder with condition flags for byte, word and long operations
// assumes operands already aligned in the low bits; purely combinational
`timescale 1ns/100ps
module aaq_adder (
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    input wire logic [1:0] size_i,
    output logic [31:0] sum_o,
    output logic [4:0] flags_o
);
    logic [32:0] s32;
    logic [16:0] s16;
    logic [8:0] s8;
    logic n;
    logic z;
    logic v;
    logic c;

    // three widths computed in parallel, the size picks one
    always_comb begin
        s32 = {1'b0, a_i} + {1'b0, b_i};
        s16 = {1'b0, a_i[15:0]} + {1'b0, b_i[15:0]};
        s8 = {1'b0, a_i[7:0]} + {1'b0, b_i[7:0]};
        sum_o = s32[31:0];
        n = s32[31];
        z = (s32[31:0] == 32'h0);
        v = (a_i[31] == b_i[31]) && (s32[31] != a_i[31]);
        c = s32[32];
        if (size_i == aaq_pkg::SZ_BYTE) begin
            sum_o = {a_i[31:8], s8[7:0]};
            n = s8[7];
            z = (s8[7:0] == 8'h0);
            v = (a_i[7] == b_i[7]) && (s8[7] != a_i[7]);
            c = s8[8];
        end else if (size_i == aaq_pkg::SZ_WORD) begin
            sum_o = {a_i[31:16], s16[15:0]};
            n = s16[15];
            z = (s16[15:0] == 16'h0);
            v = (a_i[15] == b_i[15]) && (s16[15] != a_i[15]);
            c = s16[16];
        end
        // extend copies carry
        flags_o = {c, n, z, v, c};
    end
endmodule

// file: aaq_bench.sv
// self-checking bench for the add address/immediate/quick execution unit
// assumes aaq_exec answers one cycle after start_i, outputs zero in reset
`timescale 1ns/100ps
module aaq_exec_bench;
    typedef struct packed {
        logic ill;
        logic aw;
        logic [2:0] sel;
        logic [1:0] sz;
        logic [1:0] ew;
        logic [31:0] res;
        logic [4:0] ccr;
    } aaq_exp_t;
    logic clk_i, rst_i, start_i, done_o, illegal_o, areg_wr_o;
    logic [15:0] opcode_i, ext0_i, ext1_i;
    logic [31:0] src_i, dst_i, result_o, cur_res;
    logic [4:0] ccr_i, ccr_o, cur_ccr;
    logic [2:0] areg_sel_o;
    logic [1:0] size_o, ext_words_o;
    int error_cnt = 0, n_compared = 0;
    integer seed = 32'hb4aecd43;
    aaq_exp_t meta, prv;
    logic meta_ok, prv_st;

    aaq_exec aaq_exec_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
        .opcode_i(opcode_i), .ext0_i(ext0_i), .ext1_i(ext1_i),
        .src_i(src_i), .dst_i(dst_i), .ccr_i(ccr_i), .done_o(done_o),
        .illegal_o(illegal_o), .result_o(result_o), .ccr_o(ccr_o),
        .areg_wr_o(areg_wr_o), .areg_sel_o(areg_sel_o), .size_o(size_o),
        .ext_words_o(ext_words_o));

    // 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_of_test;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // sized add done at the top of a 32-bit word so carry and sign align
    function automatic aaq_exp_t add_sz(aaq_exp_t e, logic [31:0] d,
                                        logic [31:0] b);
        logic [4:0] sh;
        logic [31:0] a, bb, r, m;
        logic [32:0] s;
        sh = e.sz == aaq_pkg::SZ_BYTE ? 5'h18 :
             e.sz == aaq_pkg::SZ_WORD ? 5'h10 : 5'h0;
        a = d << sh;
        bb = b << sh;
        s = {1'b0, a} + {1'b0, bb};
        r = s[31:0];
        m = 32'hffffffff >> sh;
        e.ill = 1'b0;
        e.res = (d & ~m) | (r >> sh);
        e.ccr = {s[32], r[31], r == 32'h0, a[31] == bb[31] && r[31] != a[31],
                 s[32]};
        return e;
    endfunction

    // reference decode; quick is tried first, as the unit does
    function automatic aaq_exp_t model(logic [15:0] op, logic [15:0] e0,
        logic [15:0] e1, logic [31:0] s, logic [31:0] d, logic [4:0] cc);
        aaq_exp_t e;
        logic [31:0] b;
        logic bad;
        e = '0;
        e.ill = 1'b1;
        e.ccr = cc;
        e.sz = op[7:6];
        bad = op[5:3] == 3'h7 && op[2:0] > 3'h1;
        if (op[15:12] == aaq_pkg::QUICK_TOP && !op[8]) begin
            if (op[7:6] != 2'h3 && !bad &&
                !(op[5:3] == 3'h1 && op[7:6] == 2'h0)) begin
                b = op[11:9] == 3'h0 ? 32'h8 : {29'h0, op[11:9]};
                if (op[5:3] == 3'h1) begin
                    e.ill = 1'b0;
                    e.aw = 1'b1;
                    e.sel = op[2:0];
                    e.res = d + b;
                end else e = add_sz(e, d, b);
            end
        end else if (op[15:12] == aaq_pkg::ADDR_TOP && op[7:6] == 2'h3) begin
            e.ill = 1'b0;
            e.aw = 1'b1;
            e.sel = op[11:9];
            e.sz = op[8] ? aaq_pkg::SZ_LONG : aaq_pkg::SZ_WORD;
            e.res = d + (op[8] ? s : {{16{s[15]}}, s[15:0]});
        end else if (op[15:8] == aaq_pkg::IMM_TOP && op[7:6] != 2'h3 && !bad
                     && op[5:3] != 3'h1) begin
            e.ew = op[7] ? 2'h2 : 2'h1;
            b = op[7] ? {e0, e1} : op[6] ? {16'h0, e0} : {24'h0, e0[7:0]};
            e = add_sz(e, d, b);
        end
        return e;
    endfunction

    // one cycle: launch a request, then judge the one launched before it
    task automatic step(logic st, logic [15:0] op, logic [15:0] e0,
        logic [15:0] e1, logic [31:0] s, logic [31:0] d, logic [4:0] cc);
        aaq_exp_t nx;
        @(posedge clk_i);
        start_i <= st;
        opcode_i <= op;
        ext0_i <= e0;
        ext1_i <= e1;
        src_i <= s;
        dst_i <= d;
        ccr_i <= cc;
        nx = model(op, e0, e1, s, d, cc);
        @(negedge clk_i);
        if (prv_st) begin
            cur_ccr = prv.ccr;
            if (!prv.ill) cur_res = prv.res;
            meta = prv;
            meta_ok = !prv.ill;
        end
        chk(done_o, prv_st & ~prv.ill); // legal ops complete
        chk(illegal_o, prv_st & prv.ill); // refused modes
        chk(areg_wr_o, prv_st & ~prv.ill & prv.aw); // address dest
        chk(result_o, cur_res); // sized sum
        chk(ccr_o, cur_ccr); // flag update
        if (meta_ok) begin
            chk(size_o, meta.sz); // size decode
            chk(ext_words_o, meta.ew); // extension words
            if (meta.aw) chk(areg_sel_o, meta.sel); // register field
        end
        prv = nx;
        prv_st = st;
    endtask

    function automatic logic [5:0] rnd_ea();
        logic [2:0] md;
        md = 3'($random(seed));
        return {md, md == 3'h7 ? 3'({$random(seed)} % 5) : 3'($random(seed))};
    endfunction

    // watchdog; the whole run takes about 2040 cycles
    initial begin
        #(100 * 5000);
        error_cnt++;
        end_of_test();
    end

    initial begin
        logic [15:0] op;
        start_i <= 1'b0;
        rst_i <= 1'b1;
        {opcode_i, ext0_i, ext1_i, src_i, dst_i, ccr_i} <= '0;
        {cur_res, cur_ccr, meta_ok, prv_st} = '0;
        prv = '0;
        meta = '0;
        // reset is sampled high at the first 20 rising edges
        repeat (19) @(posedge clk_i);
        @(negedge clk_i);
        chk({done_o, illegal_o, areg_wr_o, areg_sel_o, size_o, ext_words_o},
            32'h0); // quiet after reset
        chk(result_o | ccr_o, 32'h0); // cleared state
        @(posedge clk_i);
        rst_i <= 1'b0;
        // corner cases, back to back
        step(1, 16'h5088, 0, 0, 0, 32'h1, 5'h1f); // zero means eight
        step(1, 16'h5008, 0, 0, 0, 32'h1, 5'h0a); // byte to An refused
        step(1, 16'h5e49, 0, 0, 0, 32'hffff, 5'h15); // word to full An
        step(1, 16'h5200, 0, 0, 0, 32'h12ff, 5'h0); // byte zero
        step(1, 16'h503c, 0, 0, 0, 32'h1, 5'h03); // immediate dest
        step(1, 16'h507a, 0, 0, 0, 32'h1, 5'h03); // pc-relative dest
        step(1, 16'h0648, 16'h1, 0, 0, 32'h1, 5'h0); // An dest
        step(1, 16'h06c0, 16'h1, 0, 0, 32'h1, 5'h0); // size 11
        step(1, 16'h0600, 16'hab7f, 0, 0, 32'h1, 5'h0); // byte wrap
        step(1, 16'h0680, 0, 16'h1, 0, 32'hffffffff, 5'h0); // carry
        step(1, 16'h0678, 16'h8000, 0, 0, 32'h8000, 5'h0); // word wrap
        step(1, 16'hd4c0, 0, 0, 32'h12348000, 32'h1, 5'h1a); // sext
        step(1, 16'hd5fc, 0, 0, 32'h80000000, 32'h1, 5'h05); // long
        step(1, 16'hd2c9, 0, 0, 32'h7fff, 32'hfffffff0, 5'h11); // An
        // reset in mid-run must clear done, illegal, areg_wr, flags and result again
        step(0, 16'h0, 0, 0, 0, 0, 5'h0); // last corner judged
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk({done_o, illegal_o, areg_wr_o, ccr_o}, 32'h0); // quiet
        chk(result_o, 32'h0); // result cleared
        {cur_res, cur_ccr, meta_ok, prv_st} = '0;
        @(posedge clk_i);
        rst_i <= 1'b0;
        // random mix of the three opcodes and raw words
        repeat (2000) begin
            case ({$random(seed)} % 4)
                0: op = {4'h5, 3'($random(seed)), 1'b0, 2'($random(seed)),
                         rnd_ea()};
                1: op = {4'hd, 3'($random(seed)), 1'($random(seed)), 2'h3,
                         rnd_ea()};
                2: op = {8'h06, 2'($random(seed)), rnd_ea()};
                default: begin
                    op = 16'($random(seed));
                    if (op[5:3] == 3'h7 && op[2:0] > 3'h4) op[2] = 1'b0;
                end
            endcase
            step(($random(seed) & 7) != 0, op, 16'($random(seed)),
                 16'($random(seed)), $random(seed), $random(seed),
                 5'($random(seed))); // mix
        end
        step(0, 16'h0, 0, 0, 0, 0, 5'h0); // last result judged
        end_of_test();
    end
endmodule
